// >>> pkg/io_mode_pkg.sv
package io_mode_pkg;

	// operating modes, in button-advance order
	typedef enum logic [1:0] {MODE_BUS, MODE_PAIR_MASTER, MODE_PAIR_SLAVE} op_mode_t;

	localparam int CLK_HZ           = 100_000_000;
	localparam int CLK_NS           = 10;
	// timing figures in their own units
	localparam int DEBOUNCE_MS      = 20;
	localparam int HOLD_MS          = 2000;
	localparam int SELECT_IDLE_MS   = 4000;
	localparam int BLINK_MS         = 250;
	localparam int ACT_PULSE_MS     = 50;
	localparam int REPEAT_DELAY_MS  = 4;
	localparam int PULSE_MAX_HZ     = 20_000;
	// derived cycle counts (ms * 1e6 / period ns)
	localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * 1_000_000 / CLK_NS;
	localparam int HOLD_CYC         = HOLD_MS * 100_000;
	localparam int SELECT_IDLE_CYC  = SELECT_IDLE_MS * 100_000;
	localparam int BLINK_CYC        = BLINK_MS * 100_000;
	localparam int ACT_PULSE_CYC    = ACT_PULSE_MS * 100_000;
	localparam int REPEAT_DELAY_CYC = REPEAT_DELAY_MS * 100_000;

	// defaults loaded on mode commit, then the bus address limit and the level bar segment count less one
	localparam logic [7:0]  DEF_RADIO_ID  = 8'h11;
	localparam logic [7:0]  DEF_RETRIES   = 8'h0a;
	localparam logic [7:0]  DEF_NODE_ADDR = 8'h01;
	localparam logic [2:0]  DEF_POWER     = 3'h4;
	localparam logic [7:0]  DEF_NET_HIGH  = 8'h0c;
	localparam logic [7:0]  DEF_NET_LOW   = 8'h00;
	localparam logic [17:0] RATE_HIGH     = 18'h3d090;
	localparam logic [17:0] RATE_LOW_DEF  = 18'h1c200;
	localparam int          MAX_BUS_ADDR  = 247;
	localparam logic [2:0]  BAR_SEGS      = 3'h7;

	typedef struct packed {
		logic [7:0]  radio_id;
		logic [7:0]  retries;
		logic        encrypt_on;
		logic [7:0]  node_addr;
		logic [2:0]  power;
		logic [7:0]  network;
		logic [17:0] air_rate;
	} radio_cfg_t;

	typedef struct packed {
		logic [15:0] ain0;
		logic [15:0] ain1;
		logic [1:0]  din;
	} io_inputs_t;

	typedef struct packed {
		logic [11:0] aout0;
		logic [11:0] aout1;
		logic [1:0]  relay;
	} io_outputs_t;

endpackage : io_mode_pkg

// >>> verif/peer_radio_model.sv
module peer_radio_model (
	// clock
	input  wire logic               clk,
	// radio side toward the block
	output logic                    frame_event,
	output io_mode_pkg::io_inputs_t partner_in,
	output logic                    relay_in_valid,
	output logic [7:0]              relay_in_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		frame_event    = 1'b0;
		partner_in     = '0;
		relay_in_valid = 1'b0;
		relay_in_data  = 8'h00;
	end

	// one frame: activity pulse plus one byte offered to the repeater path
	task automatic send_frame(input logic [7:0] data);
		@(negedge clk);
		frame_event    = 1'b1;
		relay_in_valid = 1'b1;
		relay_in_data  = data;
		@(negedge clk);
		frame_event    = 1'b0;
		relay_in_valid = 1'b0;
		// a released byte lane must not look like the last byte
		relay_in_data  = ~data;
	endtask : send_frame

	// the partner's inputs, mirrored by the block in pair mode
	task automatic set_inputs(input io_mode_pkg::io_inputs_t v);
		@(negedge clk);
		partner_in = v;
	endtask : set_inputs
endmodule : peer_radio_model

// >>> verif/wireless_io_mode_indicator_bench.sv
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) begin for (k = 0; k < 400 && !(c); k++) @(negedge clk); \
	if (!(c)) begin bad_count++; summarize(); end end

module wireless_io_mode_indicator_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, sys_rst, mode_button, comm_fail, repeater_req, pulse_in;
	logic [7:0] receive_level, relay_out_data, level_bar;
	logic frame_event, relay_in_valid, relay_out_valid, act_lamp, power_lamp;
	logic [7:0] relay_in_data;
	logic [1:0] relay_state, bus_relay;
	logic [11:0] bus_aout0, bus_aout1;
	logic [2:0] mode_lamp;
	logic [3:0] io_lamp;
	logic paired_link, repeater_on, cfg_loaded;
	logic [15:0] ain_reg0, ain_reg1;
	logic [31:0] pulse_count;
	io_mode_pkg::io_inputs_t local_in, partner_in;
	io_mode_pkg::op_mode_t mode;
	io_mode_pkg::radio_cfg_t cfg, exp_cfg;
	io_mode_pkg::io_outputs_t out_drive;
	int bad_count, n_tests, k;
	// high band instance shares every input; only its refusals and defaults are judged
	logic hb_repeater_on, hb_relay_out_valid;
	io_mode_pkg::radio_cfg_t hb_cfg;

	io_mode_indicator #(.LOW_BAND(1'b1), .DEBOUNCE_CYC(4), .HOLD_CYC(20), .SELECT_IDLE_CYC(40),
		.BLINK_CYC(4), .ACT_PULSE_CYC(4), .REPEAT_DELAY_CYC(8)) io_mode_indicator_i (
		.CLK(clk), .SYS_RST(sys_rst), .MODE_BUTTON(mode_button), .RECEIVE_LEVEL(receive_level),
		.FRAME_EVENT(frame_event), .COMM_FAIL(comm_fail), .REPEATER_REQ(repeater_req),
		.PULSE_IN(pulse_in), .LOCAL_IN(local_in), .PARTNER_IN(partner_in),
		.RELAY_STATE(relay_state), .BUS_AOUT0(bus_aout0), .BUS_AOUT1(bus_aout1),
		.BUS_RELAY(bus_relay), .RELAY_IN_VALID(relay_in_valid), .RELAY_IN_DATA(relay_in_data),
		.RELAY_OUT_VALID(relay_out_valid), .RELAY_OUT_DATA(relay_out_data),
		.LEVEL_BAR(level_bar), .MODE_LAMP(mode_lamp), .ACT_LAMP(act_lamp),
		.POWER_LAMP(power_lamp), .IO_LAMP(io_lamp), .MODE(mode), .PAIRED_LINK(paired_link),
		.REPEATER_ON(repeater_on), .CFG(cfg), .CFG_LOADED(cfg_loaded), .OUT_DRIVE(out_drive),
		.AIN_REG0(ain_reg0), .AIN_REG1(ain_reg1), .PULSE_COUNT(pulse_count));

	io_mode_indicator #(.LOW_BAND(1'b0), .DEBOUNCE_CYC(4), .HOLD_CYC(20), .SELECT_IDLE_CYC(40),
		.BLINK_CYC(4), .ACT_PULSE_CYC(4), .REPEAT_DELAY_CYC(8)) io_mode_indicator_hb_i (
		.CLK(clk), .SYS_RST(sys_rst), .MODE_BUTTON(mode_button), .RECEIVE_LEVEL(receive_level),
		.FRAME_EVENT(frame_event), .COMM_FAIL(comm_fail), .REPEATER_REQ(repeater_req),
		.PULSE_IN(pulse_in), .LOCAL_IN(local_in), .PARTNER_IN(partner_in),
		.RELAY_STATE(relay_state), .BUS_AOUT0(bus_aout0), .BUS_AOUT1(bus_aout1),
		.BUS_RELAY(bus_relay), .RELAY_IN_VALID(relay_in_valid), .RELAY_IN_DATA(relay_in_data),
		.RELAY_OUT_VALID(hb_relay_out_valid), .RELAY_OUT_DATA(),
		.LEVEL_BAR(), .MODE_LAMP(), .ACT_LAMP(),
		.POWER_LAMP(), .IO_LAMP(), .MODE(), .PAIRED_LINK(),
		.REPEATER_ON(hb_repeater_on), .CFG(hb_cfg), .CFG_LOADED(), .OUT_DRIVE(),
		.AIN_REG0(), .AIN_REG1(), .PULSE_COUNT());

	peer_radio_model peer_radio_model_i (.clk(clk), .frame_event(frame_event),
		.partner_in(partner_in), .relay_in_valid(relay_in_valid),
		.relay_in_data(relay_in_data));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic press(input int n);
		repeat (n)
		begin
			mode_button = 1'b1;
			repeat (10) @(negedge clk);
			mode_button = 1'b0;
			repeat (10) @(negedge clk);
		end
	endtask : press

	task automatic level_bar_test;
		logic [7:0] lv [6] = '{8'h00, 8'h01, 8'h20, 8'h60, 8'h9f, 8'hff};
		logic [7:0] bar [6] = '{8'h00, 8'h01, 8'h03, 8'h0f, 8'h1f, 8'hff};
		for (int i = 0; i < 6; i++)
		begin
			receive_level = lv[i];
			repeat (2) @(negedge clk);
			`CHK(level_bar, bar[i])
		end
	endtask : level_bar_test

	task automatic bus_io_test;
		repeat (3)
		begin
			pulse_in = 1'b1;
			repeat (4) @(negedge clk);
			pulse_in = 1'b0;
			repeat (4) @(negedge clk);
		end
		repeat (4) @(negedge clk);
		`CHK(pulse_count, 32'h3)
		`CHK(io_lamp, 4'b0110)
		`CHK(ain_reg0, 16'hfff0)
		`CHK(ain_reg1, 16'h0001)
		`CHK(out_drive, {12'hfff, 12'h001, 2'b10})
		`CHK(paired_link, 1'b0)
		// second set of levels so no data input stays pinned for the whole run
		local_in = '{16'h0f0f, 16'hffff, 2'b01};
		relay_state = 2'b10;
		bus_aout0 = 12'h5a5;
		bus_aout1 = 12'h0ff;
		bus_relay = 2'b01;
		repeat (3) @(negedge clk);
		`CHK(io_lamp, 4'b1001)
		`CHK(ain_reg0, 16'h0f0f)
		`CHK(ain_reg1, 16'hffff)
		`CHK(out_drive, {12'h5a5, 12'h0ff, 2'b01})
	endtask : bus_io_test

	task automatic frame_test;
		peer_radio_model_i.send_frame(8'h5a);
		@(negedge clk);
		`CHK(act_lamp, 1'b1)
		repeat (4) @(negedge clk);
		`CHK(act_lamp, 1'b0)
		`CHK(relay_out_valid, 1'b0)
		comm_fail = 1'b1;
		`WAITC(power_lamp === 1'b0)
		`CHK(power_lamp, 1'b0)
		`WAITC(power_lamp === 1'b1)
		comm_fail = 1'b0;
		repeat (12) @(negedge clk);
		`CHK(power_lamp, 1'b1)
	endtask : frame_test

	task automatic repeater_test;
		repeater_req = 1'b1;
		`WAITC(repeater_on === 1'b1)
		`CHK(hb_repeater_on, 1'b0)
		peer_radio_model_i.send_frame(8'hc3);
		for (k = 1; k < 20 && relay_out_valid !== 1'b1; k++)
			@(negedge clk);
		`CHK(k, 9)
		`CHK(hb_relay_out_valid, 1'b0)
		`CHK(relay_out_data, 8'hc3)
		@(negedge clk);
		`CHK(relay_out_valid, 1'b0)
		repeater_req = 1'b0;
	endtask : repeater_test

	task automatic select_mode(input int n, input logic [2:0] cur, input logic [2:0] lamp,
		input io_mode_pkg::op_mode_t old_mode, input io_mode_pkg::op_mode_t new_mode);
		mode_button = 1'b1;
		`WAITC(mode_lamp === 3'b111)
		`CHK(mode_lamp, 3'b111)
		mode_button = 1'b0;
		`WAITC(mode_lamp === cur)
		`CHK(mode_lamp, cur)
		press(n);
		`WAITC(mode_lamp === lamp)
		`CHK(mode_lamp, lamp)
		`CHK(mode, old_mode)
		`WAITC(mode === new_mode)
		repeat (3) @(negedge clk);
		`CHK(cfg, exp_cfg)
		`CHK(cfg_loaded, 1'b1)
		`CHK(hb_cfg.network, 8'h0c)
		`CHK(hb_cfg.air_rate, 18'h3d090)
		repeat (12) @(negedge clk);
		`CHK(mode_lamp, lamp)
	endtask : select_mode

	task automatic pair_test;
		peer_radio_model_i.set_inputs('{16'habcd, 16'h1234, 2'b01});
		repeat (4) @(negedge clk);
		`CHK(out_drive, {12'habc, 12'h123, 2'b01})
		`CHK(paired_link, 1'b1)
		pulse_in = 1'b1;
		repeat (6) @(negedge clk);
		pulse_in = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(pulse_count, 32'h3)
	endtask : pair_test

	initial
	begin
		bad_count = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		mode_button = 1'b0;
		comm_fail = 1'b0;
		repeater_req = 1'b0;
		pulse_in = 1'b0;
		receive_level = 8'h00;
		local_in = '{16'hfff0, 16'h0001, 2'b10};
		relay_state = 2'b01;
		bus_aout0 = 12'hfff;
		bus_aout1 = 12'h001;
		bus_relay = 2'b10;
		exp_cfg = '{8'h11, 8'h0a, 1'b0, 8'h01, 3'h4, 8'h00, 18'h1c200};
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(mode_lamp, 3'b001)
		`CHK(power_lamp, 1'b1)
		level_bar_test();
		bus_io_test();
		frame_test();
		repeater_test();
		select_mode(2, 3'b001, 3'b100, io_mode_pkg::MODE_BUS, io_mode_pkg::MODE_PAIR_SLAVE);
		pair_test();
		select_mode(1, 3'b100, 3'b001, io_mode_pkg::MODE_PAIR_SLAVE, io_mode_pkg::MODE_BUS);
		summarize();
	end
endmodule : wireless_io_mode_indicator_bench

// >>> verilog/io_mode_indicator.sv
module io_mode_indicator #(
	parameter bit LOW_BAND         = 1'b1,
	parameter int DEBOUNCE_CYC     = io_mode_pkg::DEBOUNCE_CYC,
	parameter int HOLD_CYC         = io_mode_pkg::HOLD_CYC,
	parameter int SELECT_IDLE_CYC  = io_mode_pkg::SELECT_IDLE_CYC,
	parameter int BLINK_CYC        = io_mode_pkg::BLINK_CYC,
	parameter int ACT_PULSE_CYC    = io_mode_pkg::ACT_PULSE_CYC,
	parameter int REPEAT_DELAY_CYC = io_mode_pkg::REPEAT_DELAY_CYC
) (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	// button pin and status inputs
	input  wire logic                    MODE_BUTTON,
	input  wire logic [7:0]              RECEIVE_LEVEL,
	input  wire logic                    FRAME_EVENT,
	input  wire logic                    COMM_FAIL,
	input  wire logic                    REPEATER_REQ,
	input  wire logic                    PULSE_IN,
	// local and partner io
	input  wire io_mode_pkg::io_inputs_t LOCAL_IN,
	input  wire io_mode_pkg::io_inputs_t PARTNER_IN,
	input  wire logic [1:0]              RELAY_STATE,
	input  wire logic [11:0]             BUS_AOUT0,
	input  wire logic [11:0]             BUS_AOUT1,
	input  wire logic [1:0]              BUS_RELAY,
	// repeater frame path
	input  wire logic                    RELAY_IN_VALID,
	input  wire logic [7:0]              RELAY_IN_DATA,
	output logic                         RELAY_OUT_VALID,
	output logic [7:0]                   RELAY_OUT_DATA,
	// lamps
	output logic [7:0]                   LEVEL_BAR,
	output logic [2:0]                   MODE_LAMP,
	output logic                         ACT_LAMP,
	output logic                         POWER_LAMP,
	output logic [3:0]                   IO_LAMP,
	// configuration and data outputs
	output io_mode_pkg::op_mode_t        MODE,
	output logic                         PAIRED_LINK,
	output logic                         REPEATER_ON,
	output io_mode_pkg::radio_cfg_t      CFG,
	output logic                         CFG_LOADED,
	output io_mode_pkg::io_outputs_t     OUT_DRIVE,
	output logic [15:0]                  AIN_REG0,
	output logic [15:0]                  AIN_REG1,
	output logic [31:0]                  PULSE_COUNT
);

	typedef enum logic [1:0] {SEL_IDLE, SEL_HOLD, SEL_ALL, SEL_PICK} sel_state_t;

	function automatic io_mode_pkg::op_mode_t next_mode(input io_mode_pkg::op_mode_t m);
		next_mode = (m == io_mode_pkg::MODE_PAIR_SLAVE) ? io_mode_pkg::MODE_BUS
			: io_mode_pkg::op_mode_t'(m + 2'h1);
	endfunction : next_mode

	function automatic logic [2:0] lamp_of(input io_mode_pkg::op_mode_t m);
		lamp_of = 3'h1 << m;
	endfunction : lamp_of

	// pin synchronisers; first stage feeds only the second
	logic [1:0] btn_s_r, pulse_s_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			btn_s_r   <= 2'h0;
			pulse_s_r <= 2'h0;
		end
		else
		begin
			btn_s_r   <= {btn_s_r[0], MODE_BUTTON};
			pulse_s_r <= {pulse_s_r[0], PULSE_IN};
		end

	// debounce: level must stay put for the whole window
	logic        btn_db_r, btn_db_q_r;
	logic [31:0] db_cnt_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			btn_db_r   <= 1'b0;
			btn_db_q_r <= 1'b0;
			db_cnt_r   <= 32'h0;
		end
		else
		begin
			btn_db_q_r <= btn_db_r;
			if (btn_s_r[1] == btn_db_r)
				db_cnt_r <= 32'h0;
			else if (db_cnt_r == 32'(DEBOUNCE_CYC - 1))
			begin
				btn_db_r <= btn_s_r[1];
				db_cnt_r <= 32'h0;
			end
			else
				db_cnt_r <= db_cnt_r + 32'h1;
		end
	wire press    = btn_db_r & ~btn_db_q_r;
	wire released = ~btn_db_r & btn_db_q_r;

	// mode-selection machine
	sel_state_t            sel_r;
	io_mode_pkg::op_mode_t mode_r, cand_r;
	logic [31:0]           sel_cnt_r;
	logic                  commit_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			sel_r     <= SEL_IDLE;
			mode_r    <= io_mode_pkg::MODE_BUS;
			cand_r    <= io_mode_pkg::MODE_BUS;
			sel_cnt_r <= 32'h0;
			commit_r  <= 1'b0;
		end
		else
		begin
			commit_r <= 1'b0;
			case (sel_r)
				SEL_IDLE:
				begin
					sel_cnt_r <= 32'h0;
					if (btn_db_r)
						sel_r <= SEL_HOLD;
				end
				SEL_HOLD:
				begin
					if (!btn_db_r)
						sel_r <= SEL_IDLE;
					else if (sel_cnt_r == 32'(HOLD_CYC - 1))
					begin
						sel_r     <= SEL_ALL;
						cand_r    <= mode_r;
						sel_cnt_r <= 32'h0;
					end
					else
						sel_cnt_r <= sel_cnt_r + 32'h1;
				end
				SEL_ALL:
				begin
					sel_cnt_r <= 32'h0;
					if (released)
						sel_r <= SEL_PICK;
				end
				SEL_PICK:
				begin
					if (press)
					begin
						cand_r    <= next_mode(cand_r);
						sel_cnt_r <= 32'h0;
					end
					else if (btn_db_r)
						sel_cnt_r <= 32'h0;
					else if (sel_cnt_r == 32'(SELECT_IDLE_CYC - 1))
					begin
						mode_r   <= cand_r;
						commit_r <= 1'b1;
						sel_r    <= SEL_IDLE;
					end
					else
						sel_cnt_r <= sel_cnt_r + 32'h1;
				end
				default:
					sel_r <= SEL_IDLE;
			endcase
		end

	// blink phase shared by selection and failure lamps
	logic [31:0] blink_cnt_r;
	logic        blink_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			blink_cnt_r <= 32'h0;
			blink_r     <= 1'b0;
		end
		else if (blink_cnt_r == 32'(BLINK_CYC - 1))
		begin
			blink_cnt_r <= 32'h0;
			blink_r     <= ~blink_r;
		end
		else
			blink_cnt_r <= blink_cnt_r + 32'h1;

	// lamps
	logic [31:0] act_cnt_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			MODE_LAMP  <= 3'h0;
			POWER_LAMP <= 1'b0;
			ACT_LAMP   <= 1'b0;
			act_cnt_r  <= 32'h0;
			IO_LAMP    <= 4'h0;
			LEVEL_BAR  <= 8'h0;
		end
		else
		begin
			case (sel_r)
				SEL_ALL:  MODE_LAMP <= {3{blink_r}};
				SEL_PICK: MODE_LAMP <= blink_r ? lamp_of(cand_r) : 3'h0;
				default:  MODE_LAMP <= lamp_of(mode_r);
			endcase
			POWER_LAMP <= COMM_FAIL ? blink_r : 1'b1;
			if (FRAME_EVENT)
				act_cnt_r <= 32'(ACT_PULSE_CYC);
			else if (act_cnt_r != 32'h0)
				act_cnt_r <= act_cnt_r - 32'h1;
			ACT_LAMP <= FRAME_EVENT || act_cnt_r > 32'h1;
			IO_LAMP  <= {RELAY_STATE, LOCAL_IN.din};
			// level 0 dark; 1..255 maps to 1..8 segments
			if (RECEIVE_LEVEL == 8'h0)
				LEVEL_BAR <= 8'h0;
			else
				LEVEL_BAR <= 8'hff >> (io_mode_pkg::BAR_SEGS - RECEIVE_LEVEL[7:5]);
		end

	// defaults on commit; high band rate cannot be changed
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			CFG        <= '0;
			CFG_LOADED <= 1'b0;
		end
		else if (commit_r)
		begin
			CFG.radio_id   <= io_mode_pkg::DEF_RADIO_ID;
			CFG.retries    <= io_mode_pkg::DEF_RETRIES;
			CFG.encrypt_on <= 1'b0;
			CFG.node_addr  <= io_mode_pkg::DEF_NODE_ADDR;
			CFG.power      <= io_mode_pkg::DEF_POWER;
			CFG.network    <= LOW_BAND ? io_mode_pkg::DEF_NET_LOW : io_mode_pkg::DEF_NET_HIGH;
			CFG.air_rate   <= LOW_BAND ? io_mode_pkg::RATE_LOW_DEF
				: io_mode_pkg::RATE_HIGH;
			CFG_LOADED     <= 1'b1;
		end

	// mode outputs; pair roles are one master, one slave by configuration
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			MODE        <= io_mode_pkg::MODE_BUS;
			PAIRED_LINK <= 1'b0;
			REPEATER_ON <= 1'b0;
		end
		else
		begin
			MODE        <= mode_r;
			PAIRED_LINK <= mode_r != io_mode_pkg::MODE_BUS;
			REPEATER_ON <= REPEATER_REQ && LOW_BAND;
		end

	// repeater: hold each accepted frame byte for the relay delay; bytes offered while busy are dropped
	logic [31:0] rep_cnt_r;
	logic        rep_busy_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			rep_cnt_r       <= 32'h0;
			rep_busy_r      <= 1'b0;
			RELAY_OUT_VALID <= 1'b0;
			RELAY_OUT_DATA  <= 8'h0;
		end
		else
		begin
			RELAY_OUT_VALID <= 1'b0;
			if (!rep_busy_r && RELAY_IN_VALID && REPEATER_ON)
			begin
				rep_busy_r     <= 1'b1;
				rep_cnt_r      <= 32'h0;
				RELAY_OUT_DATA <= RELAY_IN_DATA;
			end
			else if (rep_busy_r && rep_cnt_r == 32'(REPEAT_DELAY_CYC - 1))
			begin
				rep_busy_r      <= 1'b0;
				RELAY_OUT_VALID <= 1'b1;
			end
			else if (rep_busy_r)
				rep_cnt_r <= rep_cnt_r + 32'h1;
		end

	// io data paths
	logic pulse_q_r;
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			OUT_DRIVE   <= '0;
			AIN_REG0    <= 16'h0;
			AIN_REG1    <= 16'h0;
			PULSE_COUNT <= 32'h0;
			pulse_q_r   <= 1'b0;
		end
		else
		begin
			pulse_q_r <= pulse_s_r[1];
			AIN_REG0  <= LOCAL_IN.ain0;
			AIN_REG1  <= LOCAL_IN.ain1;
			if (mode_r == io_mode_pkg::MODE_BUS)
			begin
				OUT_DRIVE <= {BUS_AOUT0, BUS_AOUT1, BUS_RELAY};
				if (pulse_s_r[1] && !pulse_q_r)
					PULSE_COUNT <= PULSE_COUNT + 32'h1;
			end
			else
				OUT_DRIVE <= {PARTNER_IN.ain0[15:4], PARTNER_IN.ain1[15:4],
					PARTNER_IN.din};
		end

	mode_valid_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_r != 2'h3) else $error("mode left the three legal values");
	commit_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		commit_r |-> sel_r == SEL_IDLE && mode_r == $past(cand_r))
		else $error("bad commit");
	defaults_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		commit_r |=> CFG.radio_id == 8'h11 && CFG.retries == 8'h0a && !CFG.encrypt_on)
		else $error("defaults not loaded");
	rate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		CFG_LOADED && !LOW_BAND |-> CFG.air_rate == 18'h3d090) else $error("rate wrong");
	no_repeat_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!LOW_BAND |-> !REPEATER_ON && !RELAY_OUT_VALID) else $error("repeater on");
	wrap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		sel_r == SEL_PICK && press && cand_r == io_mode_pkg::MODE_PAIR_SLAVE
		|=> cand_r == io_mode_pkg::MODE_BUS) else $error("no wrap");
	act_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		FRAME_EVENT |=> ACT_LAMP [*3]) else $error("activity not lit");
	power_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!COMM_FAIL |=> POWER_LAMP) else $error("power lamp off");
	bar_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		RECEIVE_LEVEL == 8'hff |=> LEVEL_BAR == 8'hff) else $error("bar not full");
	pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_r != io_mode_pkg::MODE_BUS |=> $stable(PULSE_COUNT)) else $error("count");
	cover_enter_c:  cover property (@(posedge CLK) disable iff (SYS_RST) sel_r == SEL_ALL);
	cover_commit_c: cover property (@(posedge CLK) disable iff (SYS_RST) commit_r);
	cover_relay_c:  cover property (@(posedge CLK) disable iff (SYS_RST) RELAY_OUT_VALID);

endmodule : io_mode_indicator
